// *** hdl/coe_defs.vh ***
// register map, field positions and reset values of the comparator block
`ifndef COE_DEFS_VH
`define COE_DEFS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define COE_OFS_CTRL_PRI 8'h00
`define COE_OFS_CTRL_SEC 8'h04
`define COE_OFS_STATUS 8'h08
`define COE_OFS_CLEAR 8'h0C
`define COE_OFS_TMR_CTRL 8'h10
`define COE_OFS_TMR_COUNT 8'h14
`define COE_OFS_IRQ_EN 8'h18

// ----------------------------------------------------------------
// field positions (byte lanes and bit positions within the control words)
// ----------------------------------------------------------------
`define COE_LANE_ON 0
`define COE_LANE_POL 1
`define COE_LANE_HYS 2
`define COE_LANE_SYNC 3
`define COE_LANE_RISE 0
`define COE_LANE_FALL 1
`define COE_LANE_GLOBAL 2
`define COE_BIT_PERIPH_EN 16
`define COE_BIT_GLOBAL_EN 17
`define COE_BIT_TMR_EN 0
`define COE_BIT_TMR_PRESC 1
`define COE_SEL_LSB 2
`define COE_SEL_MSB 4

// ----------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------
`define COE_RST_BYTE 8'h00
`define COE_RST_SEL 3'h0
`define COE_RESP_OKAY 2'h0
`define COE_RESP_SLVERR 2'h2
`define COE_MAX_CMP 8

`endif

// *** hdl/coe_comparator_irq.v ***
// comparator output path, edge interrupts, gated timer and register slave
`timescale 1ns/1ps
`include "coe_defs.vh"

module coe_comparator_irq #(
    parameter NUM_CMP = 2,
    parameter TMR_W = 16
) (
    input wire mclk,
    input wire rst_n,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [NUM_CMP-1:0] cmpRaw,
    input wire tmrSrcClk,
    input wire tmrPrescaledClk,
    output wire [NUM_CMP-1:0] hysteresisEnable,
    output wire [NUM_CMP-1:0] cmpOut,
    output reg timerGate,
    output reg irq
);

    localparam [7:0] CMP_MASK = 8'hFF >> (`COE_MAX_CMP - NUM_CMP);

    // ------------------------------------------------------------
    // address decode shared by the write and read paths
    // ------------------------------------------------------------
    function isOfs;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            isOfs = (addr[7:2] == ofs[7:2]);
        end
    endfunction

    function mapped;
        input [7:0] addr;
        begin
            mapped = isOfs(addr, `COE_OFS_CTRL_PRI) |
                isOfs(addr, `COE_OFS_CTRL_SEC) |
                isOfs(addr, `COE_OFS_STATUS) |
                isOfs(addr, `COE_OFS_CLEAR) |
                isOfs(addr, `COE_OFS_TMR_CTRL) |
                isOfs(addr, `COE_OFS_TMR_COUNT) |
                isOfs(addr, `COE_OFS_IRQ_EN);
        end
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    reg [7:0] onQ, polQ, hysQ, syncQ;
    reg [7:0] riseEnQ, fallEnQ, irqEnQ;
    reg periphEnQ, globalEnQ;
    reg tmrEnQ, prescQ;
    reg [2:0] selQ;
    reg [7:0] latchQ, outQ, flagQ;
    reg clkPrevQ;
    reg [TMR_W-1:0] countQ;
    reg awHeldQ, wHeldQ;
    reg [7:0] awAddrQ;
    reg [31:0] wDataQ;
    reg [3:0] wStrbQ;

    assign hysteresisEnable = hysQ[NUM_CMP-1:0];
    assign cmpOut = outQ[NUM_CMP-1:0];

    // ------------------------------------------------------------
    // write channel: address and data taken in either order
    // ------------------------------------------------------------
    wire awTake = s_axi_awvalid & s_axi_awready;
    wire wTake = s_axi_wvalid & s_axi_wready;
    wire awHas = awHeldQ | awTake;
    wire wHas = wHeldQ | wTake;
    wire wrFire = awHas & wHas & ~s_axi_bvalid;
    wire [7:0] wrAddr = awTake ? s_axi_awaddr : awAddrQ;
    wire [31:0] wrData = wTake ? s_axi_wdata : wDataQ;
    wire [3:0] wrStrb = wTake ? s_axi_wstrb : wStrbQ;
    wire wrOk = wrFire & mapped(wrAddr);
    wire bvalidD = wrFire | (s_axi_bvalid & ~s_axi_bready);
    wire awHeldD = awHas & ~wrFire;
    wire wHeldD = wHas & ~wrFire;

    wire wrPri = wrOk & isOfs(wrAddr, `COE_OFS_CTRL_PRI);
    wire wrSec = wrOk & isOfs(wrAddr, `COE_OFS_CTRL_SEC);
    wire wrClr = wrOk & isOfs(wrAddr, `COE_OFS_CLEAR);
    wire wrTmr = wrOk & isOfs(wrAddr, `COE_OFS_TMR_CTRL);
    wire wrIen = wrOk & isOfs(wrAddr, `COE_OFS_IRQ_EN);
    wire [7:0] clrVec = (wrClr & wrStrb[0]) ?
        (wrData[7:0] & CMP_MASK) : 8'h00;

    // ------------------------------------------------------------
    // comparator output path
    // ------------------------------------------------------------
    wire [7:0] rawPad;
    genvar k;
    generate
        for (k = 0; k < `COE_MAX_CMP; k = k + 1) begin : gPad
            if (k < NUM_CMP) begin : gUsed
                assign rawPad[k] = cmpRaw[k];
            end else begin : gIdle
                assign rawPad[k] = 1'b0;
            end
        end
    endgenerate

    // timer clocks are sampled levels; the mux may glitch one
    // edge when software flips the prescaler choice
    wire clkSel = prescQ ? tmrPrescaledClk : tmrSrcClk;
    wire tmrFall = clkPrevQ & ~clkSel;
    wire tmrRise = ~clkPrevQ & clkSel;

    // off forces low; inversion sits before latch and detectors
    wire [7:0] detV = onQ & (rawPad ^ polQ);
    wire [7:0] latchD = tmrFall ? detV : latchQ;
    wire [7:0] outD = (syncQ & latchD) | (~syncQ & detV);

    // detectors see on/pol changes too, so a disabled comparator
    // can still raise an edge
    wire [7:0] riseEv = outD & ~outQ & riseEnQ;
    wire [7:0] fallEv = ~outD & outQ & fallEnQ;
    wire [7:0] flagD = (flagQ & ~clrVec) | riseEv | fallEv;

    wire [7:0] gateHit;
    generate
        for (k = 0; k < `COE_MAX_CMP; k = k + 1) begin : gGate
            assign gateHit[k] = outD[k] & (selQ == k);
        end
    endgenerate

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    reg [31:0] rdVal;
    always @* begin
        rdVal = 32'h0000_0000;
        if (isOfs(s_axi_araddr, `COE_OFS_CTRL_PRI)) begin
            rdVal = {syncQ, hysQ, polQ, onQ};
        end else if (isOfs(s_axi_araddr, `COE_OFS_CTRL_SEC)) begin
            rdVal = {14'h0000, globalEnQ, periphEnQ, fallEnQ, riseEnQ};
        end else if (isOfs(s_axi_araddr, `COE_OFS_STATUS)) begin
            rdVal = {16'h0000, outQ, flagQ};
        end else if (isOfs(s_axi_araddr, `COE_OFS_TMR_CTRL)) begin
            rdVal = {27'h0000000, selQ, prescQ, tmrEnQ};
        end else if (isOfs(s_axi_araddr, `COE_OFS_TMR_COUNT)) begin
            rdVal[TMR_W-1:0] = countQ;
        end else if (isOfs(s_axi_araddr, `COE_OFS_IRQ_EN)) begin
            rdVal = {24'h000000, irqEnQ};
        end
    end

    // ------------------------------------------------------------
    // bus handshake registers
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `COE_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `COE_RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            awHeldQ <= 1'b0;
            wHeldQ <= 1'b0;
            awAddrQ <= 8'h00;
            wDataQ <= 32'h0000_0000;
            wStrbQ <= 4'h0;
        end else begin
            awHeldQ <= awHeldD;
            wHeldQ <= wHeldD;
            if (awTake) begin
                awAddrQ <= s_axi_awaddr;
            end
            if (wTake) begin
                wDataQ <= s_axi_wdata;
                wStrbQ <= s_axi_wstrb;
            end
            // no new write accepted while a response is pending
            s_axi_awready <= ~awHeldD & ~bvalidD;
            s_axi_wready <= ~wHeldD & ~bvalidD;
            s_axi_bvalid <= bvalidD;
            if (wrFire) begin
                s_axi_bresp <= mapped(wrAddr) ?
                    `COE_RESP_OKAY : `COE_RESP_SLVERR;
            end
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_arready <= 1'b0;
                s_axi_rdata <= rdVal;
                s_axi_rresp <= mapped(s_axi_araddr) ?
                    `COE_RESP_OKAY : `COE_RESP_SLVERR;
            end else if (s_axi_rvalid) begin
                s_axi_rvalid <= ~s_axi_rready;
                s_axi_arready <= s_axi_rready;
            end else begin
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        if (!rst_n) begin
            onQ <= `COE_RST_BYTE;
            polQ <= `COE_RST_BYTE;
            hysQ <= `COE_RST_BYTE;
            syncQ <= `COE_RST_BYTE;
            riseEnQ <= `COE_RST_BYTE;
            fallEnQ <= `COE_RST_BYTE;
            irqEnQ <= `COE_RST_BYTE;
            periphEnQ <= 1'b0;
            globalEnQ <= 1'b0;
            tmrEnQ <= 1'b0;
            prescQ <= 1'b0;
            selQ <= `COE_RST_SEL;
        end else begin
            if (wrPri & wrStrb[`COE_LANE_ON]) begin
                onQ <= wrData[7:0] & CMP_MASK;
            end
            if (wrPri & wrStrb[`COE_LANE_POL]) begin
                polQ <= wrData[15:8] & CMP_MASK;
            end
            if (wrPri & wrStrb[`COE_LANE_HYS]) begin
                hysQ <= wrData[23:16] & CMP_MASK;
            end
            if (wrPri & wrStrb[`COE_LANE_SYNC]) begin
                syncQ <= wrData[31:24] & CMP_MASK;
            end
            if (wrSec & wrStrb[`COE_LANE_RISE]) begin
                riseEnQ <= wrData[7:0] & CMP_MASK;
            end
            if (wrSec & wrStrb[`COE_LANE_FALL]) begin
                fallEnQ <= wrData[15:8] & CMP_MASK;
            end
            if (wrSec & wrStrb[`COE_LANE_GLOBAL]) begin
                periphEnQ <= wrData[`COE_BIT_PERIPH_EN];
                globalEnQ <= wrData[`COE_BIT_GLOBAL_EN];
            end
            if (wrIen & wrStrb[0]) begin
                irqEnQ <= wrData[7:0] & CMP_MASK;
            end
            if (wrTmr & wrStrb[0]) begin
                tmrEnQ <= wrData[`COE_BIT_TMR_EN];
                prescQ <= wrData[`COE_BIT_TMR_PRESC];
                selQ <= wrData[`COE_SEL_MSB:`COE_SEL_LSB];
            end
        end
    end

    // ------------------------------------------------------------
    // output path, flags, timer and interrupt line
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        if (!rst_n) begin
            clkPrevQ <= 1'b0;
            latchQ <= `COE_RST_BYTE;
            outQ <= `COE_RST_BYTE;
            flagQ <= `COE_RST_BYTE;
            countQ <= {TMR_W{1'b0}};
            timerGate <= 1'b0;
            irq <= 1'b0;
        end else begin
            clkPrevQ <= clkSel;
            latchQ <= latchD;
            outQ <= outD;
            // flags fall only through the clear register
            flagQ <= flagD;
            timerGate <= |gateHit;
            // counting on the opposite edge to the latch: no race
            if (tmrEnQ & tmrRise & timerGate) begin
                countQ <= countQ + 1'b1;
            end
            irq <= (|(flagD & irqEnQ)) & periphEnQ & globalEnQ;
        end
    end

endmodule // coe_comparator_irq

// *** test/coe_comparator_irq_properties.sv ***
// concurrent checks on the comparator interrupt block ports
`timescale 1ns/1ps
module coe_comparator_irq_properties #(
    parameter NUM_CMP = 2
) (
    input wire mclk,
    input wire rst_n,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [NUM_CMP-1:0] cmpOut,
    input wire timerGate,
    input wire irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    aw_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |=> s_axi_bvalid) else $error("late b");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid) else $error("b dropped");
    w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready &&
        !s_axi_wready) else $error("ready during b");
    ar_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready) else $error("late r");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
    gate_idle_a: assert property (
        ~|cmpOut |-> !timerGate) else $error("gate without output");
    irq_clear_a: assert property (
        $fell(irq) |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("irq self clear");
    // an irq rise needs a write just before it or an output change on the same edge
    irq_cause_a: assert property (
        $rose(irq) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2) ||
        cmpOut != $past(cmpOut)) else $error("irq without cause");
    cover property ($rose(irq));
    cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
    cover property ($rose(timerGate));
endmodule // coe_comparator_irq_properties
bind coe_comparator_irq coe_comparator_irq_properties #(
    .NUM_CMP(NUM_CMP)
) prop_i (.*);

// *** test/coe_timer_irq_side.sv ***
// timer clock source and interrupt controller stand-in
`timescale 1ns/1ps
module coe_timer_irq_side (
    input wire mclk,
    input wire rst_n,
    input wire irq,
    output wire tmrSrcClk,
    output wire tmrPrescaledClk,
    output int irqCount
);
    logic [4:0] div_q;
    logic irqPrev_q;
    // prescaled clock is source divided by four, as a real prescaler would
    assign tmrSrcClk = div_q[2];
    assign tmrPrescaledClk = div_q[4];
    always @(posedge mclk) begin
        if (!rst_n) begin
            div_q <= 5'h00;
            irqPrev_q <= 1'b0;
            irqCount <= 0;
        end else begin
            div_q <= div_q + 5'h01;
            irqPrev_q <= irq;
            if (irq && !irqPrev_q) begin
                irqCount <= irqCount + 1;
            end
        end
    end
endmodule // coe_timer_irq_side

// *** test/tb_coe_comparator_irq.sv ***
// self-checking bench for the comparator interrupt block
`timescale 1ns/1ps
`include "coe_defs.vh"
module tb_coe_comparator_irq;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic [1:0] cmpRaw = 2'h0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, tmrSrcClk, tmrPrescaledClk, timerGate, irq;
    wire [1:0] s_axi_bresp, s_axi_rresp, hysteresisEnable, cmpOut;
    wire [31:0] s_axi_rdata;
    logic [31:0] rdv;
    logic [1:0] rr;
    int irqCount;
    int cnt = 0, compares = 0, miscompares = 0, cycles = 0;
    coe_comparator_irq #(.NUM_CMP(2)) dut (.*);
    coe_timer_irq_side partner (.*);
    initial forever #2.5 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles > 3000) begin
            miscompares++;
            end_sim();
        end
    end
    // ----
    // bus and compare tasks
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid && !s_axi_awready ||
            s_axi_wvalid && !s_axi_wready);
        while (!s_axi_bvalid) @(posedge mclk);
        s_axi_bready <= 1'b1;
        do @(posedge mclk); while (!s_axi_bvalid);
        rr = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge mclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge mclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b1;
        do @(posedge mclk); while (!s_axi_rvalid);
        rdv = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(rdv, e);
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_regs();
        rc(`COE_OFS_CTRL_PRI, 32'h0);
        rc(`COE_OFS_CTRL_SEC, 32'h0);
        wr(`COE_OFS_CTRL_PRI, 32'hFFFFFFFF);
        rc(`COE_OFS_CTRL_PRI, 32'h03030303);
        chk(hysteresisEnable, 2'h3);
        wr(`COE_OFS_CTRL_PRI, 32'h00020000);
        chk(hysteresisEnable, 2'h2);
        wr(`COE_OFS_STATUS, 32'hFFFFFFFF);
        chk(rr, `COE_RESP_OKAY);
        rc(`COE_OFS_STATUS, 32'h0);
        rc(`COE_OFS_CLEAR, 32'h0);
        wr(8'h40, 32'h1);
        chk(rr, `COE_RESP_SLVERR);
        rc(8'h40, 32'h0);
        chk(rr, `COE_RESP_SLVERR);
    endtask
    task automatic t_irq();
        wr(`COE_OFS_IRQ_EN, 32'h1);
        wr(`COE_OFS_CTRL_SEC, 32'h00030001);
        cmpRaw <= 2'h1;
        tick(3);
        rc(`COE_OFS_STATUS, 32'h0);
        wr(`COE_OFS_CTRL_PRI, 32'h1);
        rc(`COE_OFS_STATUS, 32'h0101);
        chk(irq, 1'b1);
        wr(`COE_OFS_CTRL_SEC, 32'h00010101);
        tick(2);
        chk(irq, 1'b0);
        wr(`COE_OFS_CTRL_SEC, 32'h00030101);
        tick(3);
        // falling edge lands on the same edge that takes the clear
        cmpRaw <= 2'h0;
        wr(`COE_OFS_CLEAR, 32'h1);
        rc(`COE_OFS_STATUS, 32'h0001);
        wr(`COE_OFS_CLEAR, 32'h1);
        rc(`COE_OFS_STATUS, 32'h0);
        wr(`COE_OFS_CTRL_PRI, 32'h0101);
        rc(`COE_OFS_STATUS, 32'h0101);
        wr(`COE_OFS_CLEAR, 32'h1);
        wr(`COE_OFS_CTRL_SEC, 32'h0);
        chk(irqCount, 3);
    endtask
    task automatic t_sync(input logic presc);
        logic pc, c, e;
        int i;
        cmpRaw <= 2'h0;
        wr(`COE_OFS_CTRL_PRI, 32'h01000001);
        tick(40);
        wr(`COE_OFS_TMR_CTRL, {30'h0, presc, 1'b1});
        e = 1'b0;
        pc = presc ? tmrPrescaledClk : tmrSrcClk;
        for (i = 0; i < 90; i++) begin
            @(posedge mclk);
            c = presc ? tmrPrescaledClk : tmrSrcClk;
            if (!pc && c && timerGate) cnt++;
            if (pc && !c) e = cmpRaw[0];
            pc = c;
            if (i == 4) cmpRaw <= 2'h1;
            if (i == 50) cmpRaw <= 2'h0;
            #1;
            chk(cmpOut[0], e);
            chk(timerGate, e);
        end
        @(posedge mclk);
        rc(`COE_OFS_TMR_COUNT, cnt);
    endtask
    // gate source other than comparator 0, timer left off
    task automatic t_gate();
        wr(`COE_OFS_TMR_CTRL, 32'h00000004);
        wr(`COE_OFS_CTRL_PRI, 32'h00000003);
        cmpRaw <= 2'h1;
        tick(2);
        chk(cmpOut, 2'h1);
        chk(timerGate, 1'b0);
        cmpRaw <= 2'h2;
        tick(2);
        chk(timerGate, 1'b1);
    endtask
    task automatic end_sim();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        tick(2);
        t_regs();
        t_irq();
        t_sync(1'b0);
        t_sync(1'b1);
        t_gate();
        end_sim();
    end
endmodule // tb_coe_comparator_irq
